// file: core/dsas_pkg.sv
`default_nettype none
package dsas_pkg;
   // ==========================================
   // register port geometry
   localparam int DSAS_ADDR_W = 4; // word index width
   localparam int DSAS_DATA_W = 16; // register data width
   localparam int DSAS_RES_W = 12; // widest result word
   localparam int DSAS_CHAN_W = 4; // channel select width
   // ==========================================
   // register map, word index
   localparam logic [3:0] DSAS_CTRL_ADDR = 4'h0;
   localparam logic [3:0] DSAS_CHAN_ADDR = 4'h1;
   localparam logic [3:0] DSAS_STAT_ADDR = 4'h2;
   localparam logic [3:0] DSAS_RSLT_ADDR = 4'h3;
   localparam logic [3:0] DSAS_ISTAT_ADDR = 4'h4;
   localparam logic [3:0] DSAS_IMASK_ADDR = 4'h5;
   // ==========================================
   // control register fields
   localparam int DSAS_MODE_LSB = 0; // two bits
   localparam int DSAS_START_BIT = 2; // self clearing
   localparam int DSAS_STOP_BIT = 3; // self clearing
   localparam int DSAS_RESF_LSB = 4; // four bits
   localparam int DSAS_TPRIME_LSB = 8; // two bits
   // ==========================================
   // status and result fields
   localparam int DSAS_ST_DONE = 0;
   localparam int DSAS_ST_VALID = 1;
   localparam int DSAS_ST_BUSY = 2;
   localparam int DSAS_ST_CNT_LSB = 4; // priming count, three bits
   localparam int DSAS_RS_VALID = 15; // valid flag beside the word
   // ==========================================
   // interrupt status bits
   localparam int DSAS_IRQ_W = 2;
   localparam int DSAS_IRQ_DONE = 0;
   localparam int DSAS_IRQ_OVR = 1;
   // ==========================================
   // reset values and sequencing counts
   localparam logic [3:0] DSAS_RES_RST = 4'hC; // 12 bit
   localparam logic [3:0] DSAS_RES_MIN = 4'h8;
   localparam logic [3:0] DSAS_RES_MAX = 4'hC;
   localparam logic [1:0] DSAS_TPRIME_RST = 2'h3;
   localparam logic [1:0] DSAS_PRIME_CONV = 2'h3; // priming conversions
   localparam logic [2:0] DSAS_HIST_DEPTH = 3'h4; // samples in decimator
   localparam int DSAS_SYNC_STAGES = 3;
   // ==========================================
   // operating modes
   typedef enum logic [1:0] {
      DSAS_SINGLE,
      DSAS_MULTI,
      DSAS_CONT,
      DSAS_TURBO
   } dsas_mode_t;
endpackage : dsas_pkg
`default_nettype wire

// file: core/dsas_decim.sv
`default_nettype none
// ==========================================
// decimator: counts ones of the modulator stream per period,
// result is the sum of the last four period counts
module dsas_decim (
   // clock, reset, freeze
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // control
   input wire logic clr_i,
   input wire logic [3:0] res_i,
   // modulator stream, already synchronised
   input wire logic bit_i,
   // parallel result
   output logic conv_o,
   output logic [11:0] result_o
);
   logic [10:0] cnt_r; // position inside a period
   logic [11:0] acc_r; // ones counted so far
   logic [11:0] ones_w; // count including this bit
   logic [10:0] period_w; // clocks per conversion
   logic last_w; // final clock of a period
   logic [11:0] hist_r [4]; // last four period counts
   logic [11:0] hin_w [4]; // shift inputs
   logic [13:0] psum_w [5]; // running sums
   logic [13:0] full_w; // one past full scale

   // fewer bits give a shorter period, so a faster rate at one clock
   assign period_w = 11'(11'h1 << (res_i - 4'h2));
   assign last_w = (cnt_r == 11'(period_w - 11'h1));
   assign ones_w = acc_r + {11'h0, bit_i};

   // ==========================================
   // period counter and ones accumulator
   always_ff @(posedge clock_i) begin
      if (!resetn_i || clr_i) begin
         cnt_r <= 11'h0;
         acc_r <= 12'h0;
         conv_o <= 1'b0;
      end else if (ce_i) begin
         conv_o <= last_w; // result ready one clock later
         if (last_w) begin
            cnt_r <= 11'h0;
            acc_r <= 12'h0;
         end else begin
            cnt_r <= cnt_r + 11'h1;
            acc_r <= ones_w;
         end
      end
   end

   // ==========================================
   // four deep history, one entry per generate pass
   assign psum_w[0] = 14'h0;
   for (genvar i = 0; i < 4; i++) begin : g_hist
      if (i == 0) begin : g_head
         assign hin_w[i] = ones_w;
      end else begin : g_tail
         assign hin_w[i] = hist_r[i-1];
      end
      always_ff @(posedge clock_i) begin
         if (!resetn_i || clr_i) begin
            hist_r[i] <= 12'h0;
         end else if (ce_i && last_w) begin
            hist_r[i] <= hin_w[i];
         end
      end
      assign psum_w[i+1] = psum_w[i] + {2'h0, hist_r[i]};
   end

   // full scale input would reach 2^res, clip it to the top code
   assign full_w = 14'(14'h1 << res_i);
   assign result_o = (psum_w[4] >= full_w) ? 12'(full_w - 14'h1) : psum_w[4][11:0];
endmodule : dsas_decim
`default_nettype wire

// file: core/dsas_seq.sv
`default_nettype none

module dsas_seq (
   // clock, reset, freeze
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   // register port
   input wire logic [dsas_pkg::DSAS_ADDR_W-1:0] addr_i,
   input wire logic [dsas_pkg::DSAS_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [dsas_pkg::DSAS_DATA_W-1:0] rdata_o,
   // converter pins
   input wire logic start_i,
   input wire logic mod_bit_i,
   output logic mod_rst_o,
   output logic [dsas_pkg::DSAS_CHAN_W-1:0] chan_sel_o,
   output logic done_o,
   output logic irq_o
);
   // ==========================================
   // declarations
   typedef enum logic [1:0] {
      SQ_IDLE,
      SQ_RUN,
      SQ_HOLD
   } dsas_state_t;

   dsas_state_t state_r; // sequencer state
   dsas_pkg::dsas_mode_t mode_r; // selected mode
   logic [3:0] res_r; // requested resolution
   logic [3:0] res_w; // clamped resolution
   logic [1:0] tprime_r; // turbo priming count
   logic [1:0] need_w; // primings before a result
   logic [2:0] cnt_r; // conversions since prime start
   logic dclr_r; // holds modulator and decimator reset
   logic [1:0] pin_w; // raw pins
   logic [2:0] sync_r [2]; // three stage synchronisers
   logic lvl_r [2]; // filtered pin levels
   logic start_d_r; // previous trigger level
   logic trig_w; // any start request
   logic conv_w; // usable conversion end
   logic res_evt_w; // result produced this cycle
   logic [11:0] dec_w; // decimator word
   logic dec_conv_w; // decimator period end
   logic [11:0] rslt_r; // held result
   logic rvalid_r; // held result valid flag
   logic [2:0] since_r; // samples since channel change
   logic done_r; // conversion done flag
   logic [1:0] istat_r; // sticky events
   logic [1:0] imask_r; // event enables
   logic [1:0] ievt_w; // events this cycle
   logic wr_ctrl_w; // control write
   logic wr_chan_w; // channel write
   logic rd_rslt_w; // result read

   // ==========================================
   // pin synchronisers: a change counts when stages two and three agree
   assign pin_w = {mod_bit_i, start_i};
   for (genvar i = 0; i < 2; i++) begin : g_sync
      always_ff @(posedge clock_i) begin
         if (!resetn_i) begin
            sync_r[i] <= 3'h0;
            lvl_r[i] <= 1'b0;
         end else if (ce_i) begin
            sync_r[i] <= {sync_r[i][1:0], pin_w[i]};
            // a lone glitch never reaches the level
            if (sync_r[i][1] == sync_r[i][2]) begin
               lvl_r[i] <= sync_r[i][2];
            end
         end
      end
   end

   // trigger edge detector, works off the filtered level only
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         start_d_r <= 1'b0;
      end else if (ce_i) begin
         start_d_r <= lvl_r[0];
      end
   end

   // ==========================================
   // bus decode
   assign wr_ctrl_w = wr_i && (addr_i == dsas_pkg::DSAS_CTRL_ADDR);
   assign wr_chan_w = wr_i && (addr_i == dsas_pkg::DSAS_CHAN_ADDR);
   assign rd_rslt_w = rd_i && (addr_i == dsas_pkg::DSAS_RSLT_ADDR);

   // software start bit or rising trigger pin; a tied-low pin never fires
   assign trig_w = (wr_ctrl_w && wdata_i[dsas_pkg::DSAS_START_BIT]) || (lvl_r[0] && !start_d_r);

   // ==========================================
   // configuration registers
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         mode_r <= dsas_pkg::DSAS_SINGLE;
         res_r <= dsas_pkg::DSAS_RES_RST;
         tprime_r <= dsas_pkg::DSAS_TPRIME_RST;
      end else if (ce_i && wr_ctrl_w) begin
         // mode switch takes effect at the next decision point
         mode_r <= dsas_pkg::dsas_mode_t'(wdata_i[dsas_pkg::DSAS_MODE_LSB +: 2]);
         res_r <= wdata_i[dsas_pkg::DSAS_RESF_LSB +: 4];
         tprime_r <= wdata_i[dsas_pkg::DSAS_TPRIME_LSB +: 2];
      end
   end

   // channel select drives the input multiplexer directly
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         chan_sel_o <= 4'h0;
      end else if (ce_i && wr_chan_w) begin
         chan_sel_o <= wdata_i[3:0];
      end
   end

   // interrupt mask
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         imask_r <= 2'h0;
      end else if (ce_i && wr_i && (addr_i == dsas_pkg::DSAS_IMASK_ADDR)) begin
         imask_r <= wdata_i[1:0];
      end
   end

   // out of range resolution codes are pulled to the nearest legal one
   always_comb begin
      res_w = res_r;
      if (res_r < dsas_pkg::DSAS_RES_MIN) begin
         res_w = dsas_pkg::DSAS_RES_MIN;
      end else if (res_r > dsas_pkg::DSAS_RES_MAX) begin
         res_w = dsas_pkg::DSAS_RES_MAX;
      end
   end

   // ==========================================
   // decimator
   dsas_decim u_decim (
      .clock_i (clock_i),
      .resetn_i (resetn_i),
      .ce_i (ce_i),
      .clr_i (dclr_r),
      .res_i (res_w),
      .bit_i (lvl_r[1]),
      .conv_o (dec_conv_w),
      .result_o (dec_w)
   );

   // turbo trades settling for speed by priming fewer times
   assign need_w = (mode_r == dsas_pkg::DSAS_TURBO) ? tprime_r : dsas_pkg::DSAS_PRIME_CONV;
   // conversions finishing under reset are stale and ignored
   assign conv_w = ce_i && dec_conv_w && !dclr_r && (state_r == SQ_RUN);
   assign res_evt_w = conv_w && (cnt_r >= {1'b0, need_w});

   // ==========================================
   // sequencer state machine
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         state_r <= SQ_IDLE;
         cnt_r <= 3'h0;
         dclr_r <= 1'b1;
      end else if (ce_i) begin
         case (state_r)
            // standby: modulator held reset, nothing converts
            SQ_IDLE: begin
               dclr_r <= 1'b1;
               cnt_r <= 3'h0;
               if (trig_w) begin
                  state_r <= SQ_RUN;
               end
            end
            // converting: release reset, count primings
            SQ_RUN: begin
               dclr_r <= 1'b0;
               if (wr_ctrl_w && wdata_i[dsas_pkg::DSAS_STOP_BIT]) begin
                  state_r <= SQ_IDLE;
                  dclr_r <= 1'b1;
               end else if (res_evt_w) begin
                  case (mode_r)
                     // single: park until the result is read
                     dsas_pkg::DSAS_SINGLE: begin
                        state_r <= SQ_HOLD;
                        dclr_r <= 1'b1;
                     end
                     // continuous: keep history, result every period
                     dsas_pkg::DSAS_CONT: begin
                        state_r <= SQ_RUN;
                     end
                     // multi and turbo: reset, reprime, go again
                     default: begin
                        dclr_r <= 1'b1;
                        cnt_r <= 3'h0;
                     end
                  endcase
               end else if (conv_w) begin
                  cnt_r <= cnt_r + 3'h1;
               end
            end
            // single result waiting for readout
            SQ_HOLD: begin
               dclr_r <= 1'b1;
               if (!done_r || (wr_ctrl_w && wdata_i[dsas_pkg::DSAS_STOP_BIT])) begin
                  state_r <= SQ_IDLE;
               end
            end
            default: begin
               state_r <= SQ_IDLE;
            end
         endcase
      end
   end

   assign mod_rst_o = dclr_r;

   // ==========================================
   // samples since the last channel change
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         since_r <= 3'h0;
      end else if (ce_i) begin
         if (wr_chan_w && (wdata_i[3:0] != chan_sel_o)) begin
            since_r <= 3'h0;
         end else if (conv_w && (since_r < dsas_pkg::DSAS_HIST_DEPTH)) begin
            since_r <= since_r + 3'h1;
         end
      end
   end

   // result capture with its validity
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         rslt_r <= 12'h0;
         rvalid_r <= 1'b0;
      end else if (ce_i && res_evt_w) begin
         rslt_r <= dec_w;
         // the sample now completing counts toward the four
         rvalid_r <= (since_r >= 3'(dsas_pkg::DSAS_HIST_DEPTH - 3'h1));
      end
   end

   // ==========================================
   // done flag: a new result wins over a read in the same cycle
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         done_r <= 1'b0;
      end else if (ce_i) begin
         if (res_evt_w) begin
            done_r <= 1'b1;
         end else if (rd_rslt_w) begin
            done_r <= 1'b0;
         end
      end
   end

   assign done_o = done_r;

   // ==========================================
   // interrupt status: write one clears, set wins
   assign ievt_w = {res_evt_w && done_r && !rd_rslt_w, res_evt_w};
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         istat_r <= 2'h0;
      end else if (ce_i) begin
         if (wr_i && (addr_i == dsas_pkg::DSAS_ISTAT_ADDR)) begin
            istat_r <= (istat_r & ~wdata_i[1:0]) | ievt_w;
         end else begin
            istat_r <= istat_r | ievt_w;
         end
      end
   end

   // level interrupt, one clock behind the status bits
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         irq_o <= 1'b0;
      end else if (ce_i) begin
         irq_o <= |(istat_r & imask_r);
      end
   end

   // ==========================================
   // read data, valid only in the cycle after the strobe
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         rdata_o <= 16'h0;
      end else if (ce_i) begin
         rdata_o <= 16'h0;
         if (rd_i) begin
            if (addr_i == dsas_pkg::DSAS_CTRL_ADDR) begin
               // start and stop read back as zero
               rdata_o <= {6'h0, tprime_r, res_r, 2'h0, mode_r};
            end else if (addr_i == dsas_pkg::DSAS_CHAN_ADDR) begin
               rdata_o <= {12'h0, chan_sel_o};
            end else if (addr_i == dsas_pkg::DSAS_STAT_ADDR) begin
               rdata_o <= {9'h0, cnt_r, 1'b0, state_r != SQ_IDLE, rvalid_r, done_r};
            end else if (addr_i == dsas_pkg::DSAS_RSLT_ADDR) begin
               rdata_o <= {rvalid_r, 3'h0, rslt_r};
            end else if (addr_i == dsas_pkg::DSAS_ISTAT_ADDR) begin
               rdata_o <= {14'h0, istat_r};
            end else if (addr_i == dsas_pkg::DSAS_IMASK_ADDR) begin
               rdata_o <= {14'h0, imask_r};
            end
            // unmapped words read zero
         end
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);

   trig_start_a: assert property (
      ce_i && state_r == SQ_IDLE && trig_w |=> state_r == SQ_RUN ##1 !dclr_r || !$past(ce_i))
      else $error("trigger did not start a sequence");

   idle_quiet_a: assert property (
      state_r == SQ_IDLE |-> !res_evt_w && dclr_r)
      else $error("conversion result while in standby");

   prime_count_a: assert property (
      res_evt_w && mode_r != dsas_pkg::DSAS_TURBO |-> cnt_r == 3'h3)
      else $error("result before three primings");

   done_set_a: assert property (
      res_evt_w |=> done_o)
      else $error("done not raised after a conversion");

   done_hold_a: assert property (
      done_o && !(ce_i && rd_rslt_w) |=> done_o)
      else $error("done dropped without a result read");

   read_clear_a: assert property (
      ce_i && rd_rslt_w && !res_evt_w |=> !done_o)
      else $error("result read did not clear done");

   single_park_a: assert property (
      res_evt_w && mode_r == dsas_pkg::DSAS_SINGLE |=> state_r == SQ_HOLD && mod_rst_o)
      else $error("single mode did not park after result");

   multi_again_a: assert property (
      res_evt_w && mode_r == dsas_pkg::DSAS_MULTI && !wr_ctrl_w |=> mod_rst_o && state_r == SQ_RUN && cnt_r == 3'h0)
      else $error("multi mode did not reprime");

   cont_keep_a: assert property (
      res_evt_w && mode_r == dsas_pkg::DSAS_CONT && !wr_ctrl_w |=> !mod_rst_o && cnt_r == $past(cnt_r))
      else $error("continuous mode lost its history");

   chan_inval_a: assert property (
      ce_i && wr_chan_w && wdata_i[3:0] != chan_sel_o |=> since_r == 3'h0)
      else $error("channel change did not reset validity count");

   valid_flag_a: assert property (
      res_evt_w && since_r < 3'h3 |=> !rvalid_r)
      else $error("result flagged valid too early");
endmodule : dsas_seq
`default_nettype wire

// file: bench/dsas_mod_model.sv
`default_nettype none
// ==========================================
// modulator stand-in: fixed density stream, three ones in four
module dsas_mod_model (
   // clock and modulator reset
   input wire logic clock_i,
   input wire logic mod_rst_i,
   // serial stream
   output logic bit_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] ph_r = 2'h0; // pattern phase
   // keeps changing while held in reset, so no stale level is mistaken for data
   always @(posedge clock_i) begin
      ph_r <= mod_rst_i ? (ph_r ^ 2'h1) : (ph_r + 2'h1);
   end
   assign bit_o = (ph_r != 2'h0);
endmodule : dsas_mod_model
`default_nettype wire

// file: bench/dsas_seq_test.sv
`default_nettype none
module dsas_seq_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // design pins
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [3:0] addr_i = 4'h0;
   logic [15:0] wdata_i = 16'h0000;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic start_i = 1'b0; // trigger stays low unless a scenario pulses it
   logic ce_i = 1'b1; // clock enable, lowered only by the freeze check
   logic [15:0] rdata_o;
   logic mod_bit_i, mod_rst_o, done_o, irq_o;
   logic [3:0] chan_sel_o;
   int n_mismatch = 0; // mismatches seen
   int checks = 0; // comparisons made
   int cyc = 0; // free running cycle count
   always #50 clock_i = ~clock_i;
   always @(posedge clock_i) cyc <= cyc + 1;
   // ==========================================
   // design and far side
   dsas_seq dsas_seq_i (.clock_i, .resetn_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .start_i, .mod_bit_i, .mod_rst_o, .chan_sel_o, .done_o, .irq_o);
   dsas_mod_model dsas_mod_model_i (.clock_i(clock_i), .mod_rst_i(mod_rst_o), .bit_o(mod_bit_i));
   // ==========================================
   // compare and bus tasks, all entered just after a rising edge
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic chk_in(input string nm, input int lo, input int hi, input int got);
      checks++;
      if (got < lo || got > hi) begin
         n_mismatch++;
         $display("Error %s expected %0d to %0d seen %0d", nm, lo, hi, got);
      end
   endtask : chk_in
   // extra edge at the end so no strobe is set twice in one time step
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
      @(posedge clock_i);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      #1 d = rdata_o;
      @(posedge clock_i);
   endtask : rd
   // bounded wait for done, returns cycle stamp
   task automatic wait_done(output int t);
      int n;
      n = 0;
      while (done_o !== 1'b1 && n < 3000) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 3000) chk("done_wait", 16'h0001, 16'h0000);
      t = cyc;
   endtask : wait_done
   // control word: priming 1, resolution 8 bits (64 clock period)
   function automatic logic [15:0] ctl(input logic [1:0] m, input logic [1:0] ss);
      return {6'h00, 2'h1, 4'h8, ss, m};
   endfunction : ctl
   // ==========================================
   // scenarios
   task automatic t_reset;
      logic [15:0] d;
      chk("reset_out", 16'h0002, {12'h000, irq_o, done_o, mod_rst_o, 1'b0});
      chk("chan_sel", 16'h0000, {12'h000, chan_sel_o});
      rd(dsas_pkg::DSAS_CTRL_ADDR, d);
      chk("ctrl_reset", 16'h03C0, d);
      rd(4'hF, d);
      chk("unmapped", 16'h0000, d);
   endtask : t_reset
   task automatic t_single(input logic pin);
      int t0, t1, bad;
      logic [15:0] d;
      bad = 0;
      t0 = cyc;
      if (pin) begin
         start_i <= 1'b1;
         repeat (4) @(posedge clock_i);
         start_i <= 1'b0;
      end else begin
         wr(dsas_pkg::DSAS_CTRL_ADDR, ctl(dsas_pkg::DSAS_SINGLE, 2'b01));
      end
      wait_done(t1);
      chk_in("single_lat", 256, 280, t1 - t0);
      // frozen clock enable: the result read is lost and done holds
      ce_i <= 1'b0;
      rd(dsas_pkg::DSAS_RSLT_ADDR, d);
      chk("frozen_rd", 16'h0000, d);
      chk("frozen_done", 16'h0001, {15'h0000, done_o});
      ce_i <= 1'b1;
      rd(dsas_pkg::DSAS_STAT_ADDR, d);
      chk("stat_done", 16'h0001, {15'h0000, d[dsas_pkg::DSAS_ST_DONE]});
      rd(dsas_pkg::DSAS_RSLT_ADDR, d);
      chk("rslt_valid", 16'h0001, {15'h0000, d[15]});
      chk("done_clr", 16'h0000, {15'h0000, done_o});
      // no conversion may run in standby
      repeat (300) begin
         @(posedge clock_i);
         if (done_o !== 1'b0 || mod_rst_o !== 1'b1) bad++;
      end
      chk("standby", 16'h0000, bad[15:0]);
   endtask : t_single
   task automatic t_cont;
      int t0, t1, t2;
      logic [15:0] d;
      t0 = cyc;
      wr(dsas_pkg::DSAS_CTRL_ADDR, ctl(dsas_pkg::DSAS_CONT, 2'b01));
      wait_done(t1);
      chk_in("cont_first", 256, 272, t1 - t0);
      rd(dsas_pkg::DSAS_RSLT_ADDR, d);
      repeat (3) begin
         wait_done(t2);
         chk_in("cont_period", 64, 64, t2 - t1);
         t1 = t2;
         rd(dsas_pkg::DSAS_RSLT_ADDR, d);
      end
      // one channel throughout: continuous history must not mix inputs
      // leave a result unread so the next one overruns
      wait_done(t2);
      repeat (70) @(posedge clock_i);
      wr(dsas_pkg::DSAS_CTRL_ADDR, ctl(dsas_pkg::DSAS_CONT, 2'b10));
      repeat (2) @(posedge clock_i);
      chk("stop_rst", 16'h0001, {15'h0000, mod_rst_o});
      rd(dsas_pkg::DSAS_ISTAT_ADDR, d);
      chk("istat_ovr", 16'h0003, d);
      wr(dsas_pkg::DSAS_ISTAT_ADDR, 16'h0003);
      rd(dsas_pkg::DSAS_ISTAT_ADDR, d);
      chk("istat_w1c", 16'h0000, d);
      rd(dsas_pkg::DSAS_RSLT_ADDR, d);
   endtask : t_cont
   task automatic t_multi(input logic [1:0] m, input int lo, input int hi);
      int t1, t2;
      logic [15:0] d;
      wr(dsas_pkg::DSAS_CTRL_ADDR, ctl(m, 2'b01));
      wait_done(t1);
      rd(dsas_pkg::DSAS_RSLT_ADDR, d);
      // channel hopping belongs to multi mode: switch after the first conversion of a sample
      if (m == dsas_pkg::DSAS_MULTI) begin
         repeat (70) @(posedge clock_i);
         wr(dsas_pkg::DSAS_CHAN_ADDR, 16'h0005);
         chk("chan_sel", 16'h0005, {12'h000, chan_sel_o});
      end
      wait_done(t2);
      chk_in("multi_period", lo, hi, t2 - t1);
      if (m == dsas_pkg::DSAS_MULTI) begin
         rd(dsas_pkg::DSAS_RSLT_ADDR, d);
         chk("switch_inval", 16'h0000, {15'h0000, d[15]});
         wait_done(t2);
         rd(dsas_pkg::DSAS_RSLT_ADDR, d);
         chk("switch_valid", 16'h0001, {15'h0000, d[15]});
      end
      wr(dsas_pkg::DSAS_CTRL_ADDR, ctl(m, 2'b10));
      rd(dsas_pkg::DSAS_RSLT_ADDR, d);
      repeat (300) @(posedge clock_i);
      rd(dsas_pkg::DSAS_RSLT_ADDR, d);
   endtask : t_multi
   task automatic t_irq;
      int t1;
      logic [15:0] d;
      wr(dsas_pkg::DSAS_ISTAT_ADDR, 16'h0003);
      wr(dsas_pkg::DSAS_IMASK_ADDR, 16'h0001);
      wr(dsas_pkg::DSAS_CTRL_ADDR, ctl(dsas_pkg::DSAS_SINGLE, 2'b01));
      wait_done(t1);
      repeat (2) @(posedge clock_i);
      chk("irq_set", 16'h0001, {15'h0000, irq_o});
      rd(dsas_pkg::DSAS_RSLT_ADDR, d);
      wr(dsas_pkg::DSAS_ISTAT_ADDR, 16'h0001);
      repeat (2) @(posedge clock_i);
      chk("irq_clr", 16'h0000, {15'h0000, irq_o});
      wr(dsas_pkg::DSAS_IMASK_ADDR, 16'h0000);
      wr(dsas_pkg::DSAS_CTRL_ADDR, ctl(dsas_pkg::DSAS_SINGLE, 2'b01));
      wait_done(t1);
      repeat (2) @(posedge clock_i);
      chk("irq_mask", 16'h0000, {15'h0000, irq_o});
      rd(dsas_pkg::DSAS_RSLT_ADDR, d);
   endtask : t_irq
   // ==========================================
   // verdict, the single place where the run ends
   task automatic conclude;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // watchdog: the whole run needs about 4000 cycles
   initial begin
      repeat (20000) @(posedge clock_i);
      n_mismatch++;
      conclude();
   end
   // main sequence
   initial begin
      repeat (2) @(posedge clock_i);
      resetn_i <= 1'b1;
      @(posedge clock_i);
      t_reset();
      t_single(1'b0);
      t_single(1'b1);
      t_cont();
      t_multi(dsas_pkg::DSAS_MULTI, 256, 272);
      t_multi(dsas_pkg::DSAS_TURBO, 128, 144);
      t_irq();
      conclude();
   end
endmodule : dsas_seq_test
`default_nettype wire
